/* verification/rds_af_eon_manager_tb_top.sv */
// self-checking bench: registers, frequency stream, linked entries
// assumes the checker bind is compiled with the design
`timescale 1ns/10ps
module rds_af_eon_manager_tb_top;
   logic ref_clk, tx_next, af_valid, af_start, af_b;
   logic rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sw = 1'b0;
   logic asm_en = 1'b0;
   logic asm_slow = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] af_code;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata, link_word, rv, v;
   logic [1:0] link_sel = 2'h0;
   logic [1:0] link_field = 2'h0;
   logic [3:0] link_ann;
   logic [10:0] f;
   logic [8:0] exp_q[$];
   int bad_count = 0;
   int cmp_count = 0;
   int seed = 23;
   int cyc = 0;
   int n;
   rdsaf_top u_dut (
      .REF_CLK(ref_clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .TX_NEXT(tx_next), .AF_CODE(af_code), .AF_VALID(af_valid),
      .AF_LIST_START(af_start), .AF_METHOD_B(af_b), .LINK_SEL(link_sel), .LINK_FIELD(link_field),
      .LINK_WORD(link_word), .LINK_ANNOUNCE(link_ann), .EXTERNAL_ANNOUNCE_SWITCH(sw));
   rdsaf_asm_model u_asm (.clk(ref_clk), .rst(rst), .en(asm_en), .slow(asm_slow), .af_code(af_code),
      .af_valid(af_valid), .af_start(af_start), .tx_next(tx_next));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic summarize();
      $display("compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s %h not %h", $time, what, seen, exp);
      end
   endtask : chk
   // one strobe carries a whole command, so no line terminator is needed
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      rv = reg_rdata;
   endtask : rd
   function automatic logic [10:0] rfreq();
      return 11'h36C + 11'($unsigned($random(seed)) % 204);
   endfunction : rfreq
   // stream entry of a frequency in 100 kHz steps, 87.6 MHz codes as 1
   function automatic logic [8:0] fc(input logic [10:0] fr);
      return {1'b0, 8'(fr - 11'h36B)};
   endfunction : fc
   task automatic pull(input int cnt, input logic slow);
      u_asm.code_q.delete();
      asm_slow <= slow;
      asm_en <= 1'b1;
      for (int i = 0; i < 400 && u_asm.code_q.size() < cnt; i++) begin
         @(posedge ref_clk);
      end
      asm_en <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : pull
   // the stream runs freely, so alignment is on the first list head
   task automatic cmp_stream();
      int i;
      i = 0;
      while (i < u_asm.code_q.size() && u_asm.code_q[i][8] !== 1'b1) begin
         i++;
      end
      foreach (exp_q[j]) begin
         chk(32'(u_asm.code_q[i + j]), 32'(exp_q[j]), "stream code");
      end
   endtask : cmp_stream
   // tuning frequency, then cnt alternatives; the first one is regional
   task automatic slot(input logic [3:0] s, input int cnt);
      logic [10:0] t, a;
      wr(8'h04, 32'h8000);
      t = rfreq();
      wr(8'h04, 32'(t));
      exp_q.push_back(9'h1E0 + 9'(2 * cnt + 1));
      exp_q.push_back(fc(t));
      for (int m = 0; m < cnt; m++) begin
         a = rfreq();
         wr(8'h04, {17'h0, m == 0, 3'h0, a});
         exp_q.push_back(fc(((t < a) ^ (m == 0)) ? t : a));
         exp_q.push_back(fc(((t < a) ^ (m == 0)) ? a : t));
      end
      wr(8'h08, 32'h100 | 32'(s));
   endtask : slot
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      rd(8'h00);
      chk(rv, 32'h0, "ctrl");
      rd(8'h0C);
      chk(rv, 32'h0, "status");
      wr(8'h3C, 32'($random(seed)));
      rd(8'h3C);
      chk(rv, 32'h0, "unmapped");
      pull(4, 1'b0);
      for (n = 0; n < 4; n++) chk(32'(u_asm.code_q[n]), 32'h1CD, "empty list");
      $display("test reset done");
      wr(8'h04, 32'h8000);
      wr(8'h04, 32'h438);
      rd(8'h0C);
      chk(rv & 32'h31F01, 32'h10000, "band reject");
      wr(8'h0C, 32'h10000);
      exp_q.delete();
      exp_q.push_back(9'h1F9);
      for (n = 0; n < 26; n++) begin
         f = (n == 0) ? 11'h36C : (n == 24) ? 11'h437 : rfreq();
         wr(8'h04, 32'(f));
         if (n < 25) exp_q.push_back(fc(f));
      end
      rd(8'h0C);
      chk(rv & 32'h31F01, 32'h11900, "full list");
      wr(8'h0C, 32'h10000);
      wr(8'h10, 32'h18);
      rd(8'h10);
      chk(rv, 32'(exp_q[25]), "list entry");
      wr(8'h08, 32'h100);
      pull(60, 1'b1);
      cmp_stream();
      $display("test method A done");
      exp_q.delete();
      slot(4'h1, 2);
      slot(4'h2, 1);
      wr(8'h04, 32'h8000);
      wr(8'h08, 32'h103);
      for (n = 0; n < 6; n++) exp_q.push_back(exp_q[n]);
      wr(8'h08, 32'h201);
      rd(8'h0C);
      chk(rv & 32'h31F01, 32'h300, "loaded slot");
      wr(8'h08, 32'h203);
      rd(8'h0C);
      chk(rv & 32'h31F01, 32'h0, "end slot");
      wr(8'h00, 32'h1);
      repeat (2) @(posedge ref_clk);
      #1;
      chk(32'(af_b), 32'h1, "method B");
      wr(8'h08, 32'h102);
      rd(8'h0C);
      chk(rv & 32'h20001, 32'h20001, "edit in B");
      pull(16, 1'b0);
      chk(32'(u_asm.code_q[0]), 32'(exp_q[0]), "first head");
      cmp_stream();
      wr(8'h08, 32'h100);
      rd(8'h00);
      chk(rv, 32'h3, "stored method");
      $display("test method B done");
      for (n = 0; n < 4; n++) begin
         // link n is written and watched through field n
         v = 32'($random(seed)) & ((n == 0) ? 32'h3FFCFF : (n == 1) ? 32'hFFFFFF : 32'hFFFFFFFF);
         // regional second digit, traffic program set on the referenced link
         if (n == 0) v = v | 32'h10400;
         wr(8'(8'h40 + 20 * n), v);
         rd(8'(8'h40 + 20 * n));
         chk(rv, v, "link word");
         link_sel <= 2'(n);
         link_field <= 2'(n);
         repeat (3) @(posedge ref_clk);
         chk(link_word, v, "link port");
      end
      v = 32'($random(seed)) & 32'hF;
      wr(8'h14, v);
      rd(8'h14);
      chk(rv, v | (v << 4), "announce reg");
      chk(32'(link_ann), v, "announce port");
      wr(8'h14, 32'h0);
      sw <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rd(8'h14);
      chk(rv, 32'h10, "switch flag");
      sw <= 1'b0;
      $display("test links done");
      summarize();
   end
endmodule : rds_af_eon_manager_tb_top

/* verification/rdsaf_asm_model.sv */
// group assembler model: pulls codes and keeps {start, code} of each
// assumes codes answer one cycle after each pull
`timescale 1ns/10ps
module rdsaf_asm_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pull control
   input wire logic en,
   input wire logic slow,
   // frequency stream
   input wire logic [7:0] af_code,
   input wire logic af_valid,
   input wire logic af_start,
   output logic tx_next
);
   logic [1:0] gap_reg;
   logic [8:0] code_q[$];
   // slow mode pulls every third cycle, fast mode back to back
   always @(posedge clk) begin
      if (rst) begin
         gap_reg <= 2'h0;
         tx_next <= 1'b0;
      end else begin
         gap_reg <= (gap_reg == 2'h2) ? 2'h0 : gap_reg + 2'h1;
         tx_next <= en && (!slow || gap_reg == 2'h0);
         if (af_valid) begin
            code_q.push_back({af_start, af_code});
         end
      end
   end
endmodule : rdsaf_asm_model

/* verification/rdsaf_chk.sv */
// port assertions of the frequency manager top
// assumes a single clock domain and binding into rdsaf_top
`timescale 1ns/10ps
module rdsaf_chk #(
   parameter int SLOTS = 8,
   parameter int SLOT_MAX = 13
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // register port
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [31:0] REG_RDATA,
   // frequency stream
   input wire logic TX_NEXT,
   input wire logic [7:0] AF_CODE,
   input wire logic AF_VALID,
   input wire logic AF_LIST_START,
   input wire logic AF_METHOD_B,
   // announce flags
   input wire logic [3:0] LINK_ANNOUNCE,
   input wire logic EXTERNAL_ANNOUNCE_SWITCH
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   wire logic wr_ctrl = REG_WR && REG_ADDR == 8'h00;
   wire logic wr_ta = REG_WR && REG_ADDR == 8'h14;
   property p_valid; TX_NEXT |=> AF_VALID; endproperty
   a_valid: assert property (p_valid) else $error("no code after a pull");
   property p_no_spur; !TX_NEXT |=> !AF_VALID; endproperty
   a_no_spur: assert property (p_no_spur) else $error("code without a pull");
   // a one-edge reset may clear the code without a pull
   property p_hold; !AF_VALID && !$past(RST) |-> $stable(AF_CODE); endproperty
   a_hold: assert property (p_hold) else $error("code moved between pulls");
   property p_head; AF_LIST_START |-> AF_VALID && (AF_CODE == 8'hCD || AF_CODE inside {[8'hE0:8'hF9]}); endproperty
   a_head: assert property (p_head) else $error("bad list head");
   property p_freq; AF_VALID && !AF_LIST_START |-> AF_CODE inside {[8'h01:8'hCC]}; endproperty
   a_freq: assert property (p_freq) else $error("code outside band");
   // heads in method B count 2L-1 codes, so they are odd
   property p_bhead; AF_LIST_START && AF_METHOD_B && $past(AF_METHOD_B) && AF_CODE != 8'hCD |->
      AF_CODE[0] && AF_CODE <= 8'(8'hE0 + 2 * SLOT_MAX - 1); endproperty
   a_bhead: assert property (p_bhead) else $error("bad slot head");
   property p_rdata; !REG_RD |=> REG_RDATA == 32'h0; endproperty
   a_rdata: assert property (p_rdata) else $error("read data without read");
   property p_reset; $fell(RST) |-> !AF_METHOD_B && !AF_VALID; endproperty
   a_reset: assert property (p_reset) else $error("not method A after reset");
   property p_method; $changed(AF_METHOD_B) && !$past(RST) |-> $past(wr_ctrl) || $past(wr_ctrl, 2); endproperty
   a_method: assert property (p_method) else $error("method moved without write");
   property p_ta; $changed(LINK_ANNOUNCE[3:1]) && !$past(RST) |-> $past(wr_ta) || $past(wr_ta, 2); endproperty
   a_ta: assert property (p_ta) else $error("announce moved without write");
   property p_switch; EXTERNAL_ANNOUNCE_SWITCH [*5] |-> LINK_ANNOUNCE[0]; endproperty
   a_switch: assert property (p_switch) else $error("switch not followed");
endmodule : rdsaf_chk

bind rdsaf_top rdsaf_chk #(.SLOTS(SLOTS), .SLOT_MAX(SLOT_MAX)) u_chk (
   .REF_CLK(REF_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .TX_NEXT(TX_NEXT), .AF_CODE(AF_CODE), .AF_VALID(AF_VALID),
   .AF_LIST_START(AF_LIST_START), .AF_METHOD_B(AF_METHOD_B), .LINK_ANNOUNCE(LINK_ANNOUNCE),
   .EXTERNAL_ANNOUNCE_SWITCH(EXTERNAL_ANNOUNCE_SWITCH)
);

/* verilog/rdsaf_consts.svh */
// constants for the alternative-frequency and linked-network manager
// assumes inclusion by bare name from the frequency coder and the top module
`ifndef RDSAF_CONSTS_SVH
`define RDSAF_CONSTS_SVH

// register byte addresses
`define RDSAF_ADDR_CTRL 8'h00
`define RDSAF_ADDR_ENTRY 8'h04
`define RDSAF_ADDR_CMD 8'h08
`define RDSAF_ADDR_STATUS 8'h0C
`define RDSAF_ADDR_LIST 8'h10
`define RDSAF_ADDR_TA 8'h14
`define RDSAF_ADDR_LINK_BASE 8'h40

// field positions
`define RDSAF_CTRL_METHOD_BIT 0
`define RDSAF_ENTRY_REGION_BIT 14
`define RDSAF_ENTRY_CLEAR_BIT 15
`define RDSAF_CMD_OP_LSB 8
`define RDSAF_STAT_EREJ_BIT 16
`define RDSAF_STAT_CREJ_BIT 17

// command codes
`define RDSAF_OP_STORE 2'h1
`define RDSAF_OP_LOAD 2'h2

// capacities
`define RDSAF_LIST_A_MAX 25
`define RDSAF_SLOTS 8
`define RDSAF_SLOT_MAX 13
`define RDSAF_LINKS 4

// frequency coding, frequencies in 100 kHz units
`define RDSAF_FREQ_MIN 11'h36C
`define RDSAF_FREQ_MAX 11'h437
`define RDSAF_FREQ_BASE 11'h36B
`define RDSAF_CODE_COUNT_BASE 8'hE0
`define RDSAF_CODE_FILLER 8'hCD

// reset values
`define RDSAF_RESET_TA 4'h0

`endif

/* verilog/rdsaf_freq_code.sv */
// converts a decimal frequency in 100 kHz units to the eight-bit code
// assumes a combinational caller on the same clock
`timescale 1ns/10ps
`include "rdsaf_consts.svh"
module rdsaf_freq_code (
   // decimal frequency
   input wire logic [10:0] freq_dec,
   // code and band check
   output logic [7:0] freq_code,
   output logic freq_ok
);
   logic [10:0] offset;

   always_comb begin
      offset = freq_dec - `RDSAF_FREQ_BASE;
      freq_ok = (freq_dec >= `RDSAF_FREQ_MIN) && (freq_dec <= `RDSAF_FREQ_MAX);
      freq_code = freq_ok ? offset[7:0] : 8'h00;
   end
endmodule : rdsaf_freq_code

/* verilog/rdsaf_pkg.sv */
// types shared by the alternative-frequency manager files
// assumes nothing beyond the constants header
package rdsaf_pkg;
   typedef enum logic {
      RDSAF_METHOD_A,
      RDSAF_METHOD_B
   } rdsaf_method_t;

   // stored frequency: regional flag marks a pair sent in descending order
   typedef struct packed {
      logic regional;
      logic [7:0] code;
   } rdsaf_entry_t;
endpackage : rdsaf_pkg

/* verilog/rdsaf_sync.sv */
// two-flop synchroniser for a level coming from a pin
// assumes the level changes slowly compared with the clock
`timescale 1ns/10ps
module rdsaf_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // level in and out
   input wire logic async_in,
   output logic sync_out
);
   logic meta_reg;
   logic sync_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;
endmodule : rdsaf_sync

/* verilog/rdsaf_top.sv */
// alternative-frequency lists and linked-network entries of an rds encoder
// assumes a register master on REF_CLK and a group assembler pulling codes with TX_NEXT
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`include "rdsaf_consts.svh"

module rdsaf_top import rdsaf_pkg::*; #(
   parameter int SLOTS = `RDSAF_SLOTS,
   parameter int SLOT_MAX = `RDSAF_SLOT_MAX
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   // frequency stream to the group assembler
   input wire logic TX_NEXT,
   output logic [7:0] AF_CODE,
   output logic AF_VALID,
   output logic AF_LIST_START,
   output logic AF_METHOD_B,
   // linked-network data to the group assembler
   input wire logic [1:0] LINK_SEL,
   input wire logic [1:0] LINK_FIELD,
   output logic [31:0] LINK_WORD,
   output logic [3:0] LINK_ANNOUNCE,
   // external announce switch pin
   input wire logic EXTERNAL_ANNOUNCE_SWITCH
);
   localparam int LIST_A = `RDSAF_LIST_A_MAX;
   localparam int SLOT_WORDS = SLOTS * SLOT_MAX;

   if (SLOTS < 1 || SLOTS > 8 || SLOT_MAX < 2 || SLOT_MAX > 13) begin : g_check
      $error("rdsaf_top: slot geometry exceeds counter widths");
   end

   function automatic logic [6:0] slot_index(input logic [2:0] s, input logic [3:0] i);
      slot_index = 7'(s * SLOT_MAX + i);
   endfunction : slot_index

   // state
   rdsaf_method_t method_reg, method_next;
   rdsaf_method_t stored_method_reg, stored_method_next;
   rdsaf_entry_t work_reg [LIST_A];
   rdsaf_entry_t work_next [LIST_A];
   logic [4:0] work_len_reg, work_len_next;
   rdsaf_entry_t lista_reg [LIST_A];
   rdsaf_entry_t lista_next [LIST_A];
   logic [4:0] lista_len_reg, lista_len_next;
   rdsaf_entry_t slot_reg [SLOT_WORDS];
   rdsaf_entry_t slot_next [SLOT_WORDS];
   logic [3:0] slot_len_reg [SLOTS];
   logic [3:0] slot_len_next [SLOTS];
   logic erej_reg, erej_next;
   logic crej_reg, crej_next;
   logic [4:0] rd_idx_reg, rd_idx_next;
   logic [3:0] sw_ta_reg, sw_ta_next;
   logic [21:0] link_ident_reg [`RDSAF_LINKS];
   logic [21:0] link_ident_next [`RDSAF_LINKS];
   logic [23:0] link_pin_reg [`RDSAF_LINKS];
   logic [23:0] link_pin_next [`RDSAF_LINKS];
   logic [63:0] link_name_reg [`RDSAF_LINKS];
   logic [63:0] link_name_next [`RDSAF_LINKS];
   logic [2:0] tx_slot_reg, tx_slot_next;
   logic [3:0] tx_idx_reg, tx_idx_next;
   logic tx_half_reg, tx_half_next;
   logic [4:0] txa_idx_reg, txa_idx_next;
   logic [7:0] af_code_reg, af_code_next;
   logic af_valid_reg, af_valid_next;
   logic af_start_reg, af_start_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [31:0] link_word_reg, link_word_next;
   logic [3:0] announce_reg, announce_next;

   logic [7:0] entry_code;
   logic entry_ok;
   logic ext_sw;
   logic [3:0] eff_ta;

   rdsaf_freq_code u_code (
      .freq_dec(REG_WDATA[10:0]),
      .freq_code(entry_code),
      .freq_ok(entry_ok)
   );

   rdsaf_sync u_sync (
      .clk(REF_CLK),
      .rst(RST),
      .async_in(EXTERNAL_ANNOUNCE_SWITCH),
      .sync_out(ext_sw)
   );

   // first link follows switch or software, either can raise it
   assign eff_ta = sw_ta_reg | {3'h0, ext_sw};

   always_comb begin
      logic [2:0] s;
      logic [3:0] slen;
      logic [3:0] op_slot;
      logic [1:0] op;
      logic [1:0] lk;
      rdsaf_entry_t tun;
      rdsaf_entry_t af;
      logic [7:0] lo;
      logic [7:0] hi;
      logic wr_entry;
      logic wr_cmd;
      s = 3'h0;
      slen = 4'h0;
      op_slot = REG_WDATA[3:0];
      op = REG_WDATA[`RDSAF_CMD_OP_LSB+1:`RDSAF_CMD_OP_LSB];
      lk = REG_ADDR[5:4];
      tun = '0;
      af = '0;
      lo = 8'h00;
      hi = 8'h00;
      wr_entry = REG_WR && (REG_ADDR == `RDSAF_ADDR_ENTRY);
      wr_cmd = REG_WR && (REG_ADDR == `RDSAF_ADDR_CMD);
      method_next = method_reg;
      stored_method_next = stored_method_reg;
      work_next = work_reg;
      work_len_next = work_len_reg;
      lista_next = lista_reg;
      lista_len_next = lista_len_reg;
      slot_next = slot_reg;
      slot_len_next = slot_len_reg;
      erej_next = erej_reg;
      crej_next = crej_reg;
      rd_idx_next = rd_idx_reg;
      sw_ta_next = sw_ta_reg;
      link_ident_next = link_ident_reg;
      link_pin_next = link_pin_reg;
      link_name_next = link_name_reg;
      tx_slot_next = tx_slot_reg;
      tx_idx_next = tx_idx_reg;
      tx_half_next = tx_half_reg;
      txa_idx_next = txa_idx_reg;
      af_code_next = af_code_reg;
      af_valid_next = 1'b0;
      af_start_next = 1'b0;
      rdata_next = 32'h0000_0000;
      announce_next = eff_ta;

      // clears first, so a reject in the same cycle wins
      if (REG_WR && REG_ADDR == `RDSAF_ADDR_STATUS) begin
         if (REG_WDATA[`RDSAF_STAT_EREJ_BIT]) erej_next = 1'b0;
         if (REG_WDATA[`RDSAF_STAT_CREJ_BIT]) crej_next = 1'b0;
      end
      if (REG_WR && REG_ADDR == `RDSAF_ADDR_CTRL) begin
         method_next = rdsaf_method_t'(REG_WDATA[`RDSAF_CTRL_METHOD_BIT]);
         if (method_next == RDSAF_METHOD_B && method_reg == RDSAF_METHOD_A) begin
            tx_slot_next = 3'h0;
            tx_idx_next = 4'h0;
            tx_half_next = 1'b0;
         end
      end
      if (REG_WR && REG_ADDR == `RDSAF_ADDR_LIST) rd_idx_next = REG_WDATA[4:0];
      if (REG_WR && REG_ADDR == `RDSAF_ADDR_TA) sw_ta_next = REG_WDATA[3:0];
      if (REG_WR && REG_ADDR[7:6] == 2'h1) begin
         unique case (REG_ADDR[3:2])
            2'h0: link_ident_next[lk] = REG_WDATA[21:0];
            2'h1: link_pin_next[lk] = REG_WDATA[23:0];
            2'h2: link_name_next[lk][31:0] = REG_WDATA;
            2'h3: link_name_next[lk][63:32] = REG_WDATA;
         endcase
      end

      if (wr_entry) begin
         if (REG_WDATA[`RDSAF_ENTRY_CLEAR_BIT]) begin
            work_len_next = 5'h00;
         end else if (entry_ok && work_len_reg < 5'(LIST_A)) begin
            work_next[work_len_reg] = '{regional: REG_WDATA[`RDSAF_ENTRY_REGION_BIT], code: entry_code};
            work_len_next = work_len_reg + 5'h01;
         end else begin
            erej_next = 1'b1;
         end
      end

      if (wr_cmd) begin
         s = 3'(op_slot - 4'h1);
         if (op == `RDSAF_OP_STORE && op_slot == 4'h0) begin
            lista_next = work_reg;
            lista_len_next = work_len_reg;
            stored_method_next = method_reg;
         end else if (op_slot == 4'h0 || op_slot > 4'(SLOTS) || method_reg != RDSAF_METHOD_A) begin
            crej_next = 1'b1;
         end else if (op == `RDSAF_OP_STORE) begin
            if (work_len_reg > 5'(SLOT_MAX)) begin
               crej_next = 1'b1;
            end else begin
               for (int i = 0; i < SLOT_MAX; i++) begin
                  slot_next[slot_index(s, 4'(i))] = work_reg[i];
               end
               slot_len_next[s] = work_len_reg[3:0];
            end
         end else if (op == `RDSAF_OP_LOAD) begin
            for (int i = 0; i < SLOT_MAX; i++) begin
               work_next[i] = slot_reg[slot_index(s, 4'(i))];
            end
            work_len_next = {1'b0, slot_len_reg[s]};
         end else begin
            crej_next = 1'b1;
         end
      end

      if (REG_RD) begin
         unique case (REG_ADDR)
            `RDSAF_ADDR_CTRL: rdata_next = {30'h0, stored_method_reg, method_reg};
            `RDSAF_ADDR_STATUS: rdata_next = {8'h00, 1'b0, tx_slot_reg, 2'h0, crej_reg, erej_reg,
                                              3'h0, work_len_reg, 7'h00, method_reg};
            `RDSAF_ADDR_LIST: rdata_next = (rd_idx_reg < work_len_reg) ?
                                           {23'h0, work_reg[rd_idx_reg]} : 32'h0000_0000;
            `RDSAF_ADDR_TA: rdata_next = {24'h0, eff_ta, sw_ta_reg};
            default: begin
               if (REG_ADDR[7:6] == 2'h1) begin
                  unique case (REG_ADDR[3:2])
                     2'h0: rdata_next = {10'h0, link_ident_reg[lk]};
                     2'h1: rdata_next = {8'h00, link_pin_reg[lk]};
                     2'h2: rdata_next = link_name_reg[lk][31:0];
                     2'h3: rdata_next = link_name_reg[lk][63:32];
                  endcase
               end
            end
         endcase
      end

      unique case (LINK_FIELD)
         2'h0: link_word_next = {10'h0, link_ident_reg[LINK_SEL]};
         2'h1: link_word_next = {8'h00, link_pin_reg[LINK_SEL]};
         2'h2: link_word_next = link_name_reg[LINK_SEL][31:0];
         2'h3: link_word_next = link_name_reg[LINK_SEL][63:32];
      endcase

      // method A: count code then each stored code, repeating
      if (TX_NEXT && method_reg == RDSAF_METHOD_A) begin
         af_valid_next = 1'b1;
         if (txa_idx_reg == 5'h00) begin
            af_start_next = 1'b1;
            af_code_next = (lista_len_reg == 5'h00) ? `RDSAF_CODE_FILLER :
                           `RDSAF_CODE_COUNT_BASE + {3'h0, lista_len_reg};
         end else begin
            af_code_next = lista_reg[txa_idx_reg - 5'h01].code;
         end
         txa_idx_next = (txa_idx_reg >= lista_len_reg) ? 5'h00 : txa_idx_reg + 5'h01;
      end

      // method B: count, tuning, then pairs; next slot follows at once
      if (TX_NEXT && method_reg == RDSAF_METHOD_B) begin
         slen = slot_len_reg[tx_slot_reg];
         tun = slot_reg[slot_index(tx_slot_reg, 4'h0)];
         af = slot_reg[slot_index(tx_slot_reg, tx_idx_reg - 4'h1)];
         lo = (tun.code < af.code) ? tun.code : af.code;
         hi = (tun.code < af.code) ? af.code : tun.code;
         af_valid_next = 1'b1;
         if (slen == 4'h0) begin
            af_start_next = 1'b1;
            af_code_next = `RDSAF_CODE_FILLER;
            tx_slot_next = 3'h0;
            tx_idx_next = 4'h0;
         end else if (tx_idx_reg == 4'h0) begin
            af_start_next = 1'b1;
            af_code_next = `RDSAF_CODE_COUNT_BASE + {3'h0, slen, 1'b0} - 8'h01;
            tx_idx_next = 4'h1;
         end else if (tx_idx_reg == 4'h1) begin
            af_code_next = tun.code;
            tx_idx_next = 4'h2;
         end else begin
            af_code_next = (tx_half_reg ^ af.regional) ? hi : lo;
            tx_half_next = ~tx_half_reg;
            if (tx_half_reg) tx_idx_next = tx_idx_reg + 4'h1;
         end
         // last element of this slot sent: move on or wrap at the terminator
         if (slen != 4'h0 && ((tx_idx_reg == 4'h1 && slen == 4'h1) ||
             (tx_idx_reg >= 4'h2 && tx_half_reg && tx_idx_reg == slen))) begin
            tx_idx_next = 4'h0;
            tx_half_next = 1'b0;
            s = tx_slot_reg + 3'h1;
            tx_slot_next = (32'(tx_slot_reg) == SLOTS - 1 || slot_len_reg[s] == 4'h0) ? 3'h0 : s;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         method_reg <= RDSAF_METHOD_A;
         stored_method_reg <= RDSAF_METHOD_A;
         work_len_reg <= 5'h00;
         lista_len_reg <= 5'h00;
         for (int i = 0; i < SLOTS; i++) slot_len_reg[i] <= 4'h0;
         erej_reg <= 1'b0;
         crej_reg <= 1'b0;
         rd_idx_reg <= 5'h00;
         sw_ta_reg <= `RDSAF_RESET_TA;
         for (int i = 0; i < `RDSAF_LINKS; i++) begin
            link_ident_reg[i] <= 22'h000000;
            link_pin_reg[i] <= 24'h000000;
            link_name_reg[i] <= 64'h0;
         end
         tx_slot_reg <= 3'h0;
         tx_idx_reg <= 4'h0;
         tx_half_reg <= 1'b0;
         txa_idx_reg <= 5'h00;
         af_code_reg <= 8'h00;
         af_valid_reg <= 1'b0;
         af_start_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         link_word_reg <= 32'h0000_0000;
         announce_reg <= 4'h0;
      end else begin
         method_reg <= method_next;
         stored_method_reg <= stored_method_next;
         work_len_reg <= work_len_next;
         lista_len_reg <= lista_len_next;
         slot_len_reg <= slot_len_next;
         erej_reg <= erej_next;
         crej_reg <= crej_next;
         rd_idx_reg <= rd_idx_next;
         sw_ta_reg <= sw_ta_next;
         link_ident_reg <= link_ident_next;
         link_pin_reg <= link_pin_next;
         link_name_reg <= link_name_next;
         tx_slot_reg <= tx_slot_next;
         tx_idx_reg <= tx_idx_next;
         tx_half_reg <= tx_half_next;
         txa_idx_reg <= txa_idx_next;
         af_code_reg <= af_code_next;
         af_valid_reg <= af_valid_next;
         af_start_reg <= af_start_next;
         rdata_reg <= rdata_next;
         link_word_reg <= link_word_next;
         announce_reg <= announce_next;
      end
   end

   // list contents need no reset: lengths gate every read of them
   always_ff @(posedge REF_CLK) begin
      work_reg <= work_next;
      lista_reg <= lista_next;
      slot_reg <= slot_next;
   end

   assign REG_RDATA = rdata_reg;
   assign AF_CODE = af_code_reg;
   assign AF_VALID = af_valid_reg;
   assign AF_LIST_START = af_start_reg;
   assign AF_METHOD_B = method_reg;
   assign LINK_WORD = link_word_reg;
   assign LINK_ANNOUNCE = announce_reg;
endmodule : rdsaf_top
